// [hdl/uad_defines.vh]
// Constants for the accessory detect and switch control block.
// Included by the design files; definitions only.
`ifndef UAD_DEFINES_VH
`define UAD_DEFINES_VH
`define UAD_ADC_W          5
`define UAD_ADC_KEY_LO     5'h01
`define UAD_ADC_KEY_HI     5'h0d
`define UAD_ADC_JIG_USB0   5'h18
`define UAD_ADC_JIG_USB1   5'h19
`define UAD_ADC_JIG_UART0  5'h1c
`define UAD_ADC_JIG_UART1  5'h1d
`define UAD_ADC_AUDIO1     5'h1e
`define UAD_ADC_OPEN       5'h1f
`define UAD_ADC_ALT_SE0    5'h10
`define UAD_ADC_ALT_SE1    5'h11
`define UAD_ADC_RESET      5'h1f
`define UAD_CHG_NONE       3'h0
`define UAD_CHG_SDP        3'h1
`define UAD_CHG_CDP        3'h2
`define UAD_CHG_DCP        3'h3
`define UAD_CHG_NONCOMP    3'h4
`define UAD_OCP_TMO_W      8
`define UAD_OCP_TMO_RESET  8'h0a
`define UAD_BTN_W          13
`define UAD_CMP_SETTLE     2'h2
`endif

// [hdl/uad_ocp_timer.v]
// Overcurrent timeout for the VBUS load switch.
// Assumes over_thr is already synchronised to clk.
`timescale 1ns/10ps
module uad_ocp_timer
(
  input  wire       clk,       // System clock
  input  wire       rst_n,     // Synchronous reset, active low
  input  wire       enable,    // Load switch requested on
  input  wire       over_thr,  // Current above trip threshold
  input  wire [7:0] timeout,   // Programmed delay in cycles
  output reg        trip       // Load switch disabled by overcurrent
);
  reg [7:0] cnt_reg;
  reg       run_reg;

  always @(posedge clk)
  begin
    if (!rst_n || !enable)
    begin
      cnt_reg <= 8'h00;
      run_reg <= 1'b0;
      trip    <= 1'b0;
    end
    else if (!trip)
    begin
      if (over_thr && !run_reg)
      begin
        run_reg <= 1'b1;
        cnt_reg <= 8'h00;
      end
      else if (run_reg)
      begin
        // trip if still over at expiry
        if (cnt_reg >= timeout)
        begin
          run_reg <= 1'b0;
          trip    <= over_thr;
        end
        else
          cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end
endmodule // uad_ocp_timer

// [hdl/uad_ctrl.v]
// Accessory classification and switch matrix control.
// Supply presence, comparator and current levels arrive asynchronously.
`timescale 1ns/10ps
`include "uad_defines.vh"
module uad_ctrl
(
  input  wire        clk,              // System clock 25 MHz
  input  wire        rst_n,            // Synchronous reset, active low
  input  wire        vbat_ok,          // Battery above power-on threshold
  input  wire        vbus_ok,          // VBUS present (above 4 V)
  input  wire        io_supply,        // Register supply present
  input  wire        id_cmp_hi,        // ID voltage above reference
  input  wire        id_attached,      // ID comparator sees a resistor
  input  wire        conn_dplus,       // D+ sensed driven/low state
  input  wire        conn_dminus,      // D- sensed driven/low state
  input  wire        dlines_short,     // D+ shorted to D-
  input  wire        dminus_src,       // D- sourcing 0.6 V
  input  wire        over_thr,         // Overcurrent trip threshold hit
  input  wire        alt_mode,         // Alternate accessory mode
  input  wire        int_mask,         // Interrupt mask control bit
  input  wire        sw_reset,         // Host wrote reset bit (pulse)
  input  wire        int_rd,           // Host read of interrupt reg
  input  wire        reg_wr,           // Host register write strobe
  input  wire        key_stable,       // Remote key held level
  input  wire [7:0]  ocp_timeout,      // Overcurrent delay in cycles
  output reg         sw_usb,           // USB path closed
  output reg         sw_uart,          // UART path closed
  output reg         sw_audio,         // Audio path closed
  output reg         sw_vbus_mic,      // VBUS to MIC closed
  output reg         sw_dm_left,       // D- to left audio
  output reg         sw_dp_mic,        // D+ to MIC
  output reg         id_bypass_switch, // ID bypass closed
  output reg         charge_current_out, // Charge current status
  output reg         factory_cable_out,  // Factory jig status
  output reg         boot_out,         // Boot status
  output reg         load_sw_en,       // Load switch enabled
  output reg         current_limit_en, // Current limit on while VBUS present and over threshold
  output reg         id_src_en,        // ID current source on
  output reg         reg_access_en,    // Register access allowed
  output reg  [4:0]  adc_code,         // Converted ID code
  output reg  [2:0]  charger_type,     // Detected charger type
  output reg         short_keypress_flag, // Key press interrupt flag
  output reg  [12:0] button_bits,      // Button register bits
  output reg         irq_out_n,        // Interrupt, active low
  output reg         standby           // No accessory detected
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_MON  = 2'h2;

  reg [1:0]  st_reg;
  reg [4:0]  ref_reg;
  reg [9:0]  s1_reg;
  reg [9:0]  s2_reg;
  reg [1:0]  settle_reg;
  reg        key_prev_reg;
  reg        mask_hold_reg;
  wire       trip;
  wire       live_rst;
  wire       vbat_s;
  wire       vbus_s;
  wire       io_s;
  wire       cmp_s;
  wire       att_s;
  wire       dp_s;
  wire       dm_s;
  wire       sh_s;
  wire       src_s;
  wire       oc_s;

  // Two-stage synchronisers for the ten supply, ID, D-line and overcurrent inputs
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      s1_reg <= 10'h000;
      s2_reg <= 10'h000;
    end
    else
    begin
      s1_reg <= {vbat_ok, vbus_ok, io_supply, id_cmp_hi, id_attached,
                 conn_dplus, conn_dminus, dlines_short, dminus_src, over_thr};
      s2_reg <= s1_reg;
    end
  end
  assign {vbat_s, vbus_s, io_s, cmp_s, att_s, dp_s, dm_s, sh_s, src_s,
          oc_s} = s2_reg;

  assign live_rst = !rst_n || sw_reset || (!vbat_s && !vbus_s);

  function is_key;
    input [4:0] c;
    begin
      is_key = (c >= `UAD_ADC_KEY_LO) && (c <= `UAD_ADC_KEY_HI);
    end
  endfunction

  uad_ocp_timer u_ocp
  (
    .clk      (clk),
    .rst_n    (!live_rst),
    .enable   (vbus_s),
    .over_thr (oc_s),
    .timeout  (ocp_timeout),
    .trip     (trip)
  );

  // Conversion: ramp reference until it reaches the ID voltage
  always @(posedge clk)
  begin
    if (live_rst)
    begin
      st_reg    <= ST_IDLE;
      ref_reg   <= 5'h00;
      settle_reg <= 2'h0;
      adc_code  <= `UAD_ADC_RESET;
      id_src_en <= 1'b0;
      standby   <= 1'b1;
    end
    else
    begin
      case (st_reg)
        ST_IDLE:
        begin
          standby   <= 1'b1;
          adc_code  <= `UAD_ADC_OPEN;
          id_src_en <= 1'b0;
          if (att_s && (!vbus_s ||
              charger_type == `UAD_CHG_NONCOMP))
          begin
            st_reg    <= ST_CONV;
            ref_reg   <= 5'h00;
            adc_code  <= 5'h00;
            settle_reg <= 2'h0;
            id_src_en <= 1'b1;
            standby   <= 1'b0;
          end
        end
        ST_CONV:
        begin
          // step reference upward
          // Reference shows on adc_code; answer returns via synchroniser
          if (settle_reg != `UAD_CMP_SETTLE)
            settle_reg <= settle_reg + 2'h1;
          else if (!cmp_s || ref_reg == 5'h1f)
          begin
            adc_code <= ref_reg;
            st_reg   <= ST_MON;
          end
          else
          begin
            ref_reg    <= ref_reg + 5'h01;
            adc_code   <= ref_reg + 5'h01;
            settle_reg <= 2'h0;
          end
        end
        ST_MON:
        begin
          // current source kept on to see detach
          id_src_en <= 1'b1;
          if (!att_s)
            st_reg <= ST_IDLE;
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  always @(posedge clk)
  begin
    if (live_rst)
      charger_type <= `UAD_CHG_NONE;
    else if (!vbus_s)
      charger_type <= `UAD_CHG_NONE;
    else if (sh_s)
      charger_type <= `UAD_CHG_DCP;
    else if (src_s)
      charger_type <= `UAD_CHG_CDP;
    else if (!dp_s && !dm_s)
      charger_type <= `UAD_CHG_NONCOMP;
    else
      charger_type <= `UAD_CHG_SDP;
  end

  // Switch matrix decode, registered
  always @(posedge clk)
  begin
    if (live_rst)
    begin
      sw_usb             <= 1'b0;
      sw_uart            <= 1'b0;
      sw_audio           <= 1'b0;
      sw_vbus_mic        <= 1'b0;
      sw_dm_left         <= 1'b0;
      sw_dp_mic          <= 1'b0;
      id_bypass_switch   <= 1'b0;
      charge_current_out <= 1'b0;
      factory_cable_out  <= 1'b0;
      boot_out           <= 1'b0;
    end
    else
    begin
      sw_usb             <= 1'b0;
      sw_uart            <= 1'b0;
      sw_audio           <= 1'b0;
      sw_vbus_mic        <= 1'b0;
      sw_dm_left         <= 1'b0;
      sw_dp_mic          <= 1'b0;
      id_bypass_switch   <= 1'b0;
      charge_current_out <= 1'b0;
      factory_cable_out  <= 1'b0;
      boot_out           <= 1'b0;
      if (st_reg == ST_MON && alt_mode)
      begin
        if (adc_code == `UAD_ADC_JIG_UART0 ||
            adc_code == `UAD_ADC_JIG_UART1)
        begin
          sw_dm_left <= 1'b1;
          sw_dp_mic  <= 1'b1;
        end
        else if (adc_code == `UAD_ADC_ALT_SE0 ||
                 adc_code == `UAD_ADC_ALT_SE1)
        begin
          sw_audio    <= 1'b1;
          sw_vbus_mic <= !vbus_s;
        end
      end
      else if (st_reg == ST_MON)
      begin
        if (is_key(adc_code) || adc_code == `UAD_ADC_AUDIO1)
        begin
          sw_audio    <= 1'b1;
          sw_vbus_mic <= 1'b1;
        end
        else if (adc_code == `UAD_ADC_JIG_USB0 ||
                 adc_code == `UAD_ADC_JIG_USB1)
        begin
          sw_usb            <= 1'b1;
          factory_cable_out <= 1'b1;
          boot_out          <= (adc_code == `UAD_ADC_JIG_USB1);
        end
        else if (adc_code == `UAD_ADC_JIG_UART0 ||
                 adc_code == `UAD_ADC_JIG_UART1)
        begin
          sw_uart           <= 1'b1;
          factory_cable_out <= 1'b1;
          boot_out          <= (adc_code == `UAD_ADC_JIG_UART1);
        end
      end
      else if (vbus_s && adc_code == `UAD_ADC_OPEN)
      begin
        if (charger_type == `UAD_CHG_SDP)
        begin
          sw_usb           <= 1'b1;
          id_bypass_switch <= 1'b1;
        end
        else if (charger_type == `UAD_CHG_CDP ||
                 charger_type == `UAD_CHG_DCP)
        begin
          sw_usb             <= 1'b1;
          id_bypass_switch   <= 1'b1;
          charge_current_out <= 1'b1;
        end
      end
    end
  end

  // Load switch and register supply gating
  always @(posedge clk)
  begin
    if (live_rst)
    begin
      load_sw_en       <= 1'b0;
      current_limit_en <= 1'b0;
      reg_access_en    <= 1'b0;
    end
    else
    begin
      load_sw_en       <= vbus_s && !trip;
      current_limit_en <= vbus_s && oc_s;
      reg_access_en    <= vbat_s && io_s;
    end
  end

  // Key press flag and interrupt pin
  always @(posedge clk)
  begin
    if (!rst_n || (!vbat_s && !vbus_s))
    begin
      key_prev_reg        <= 1'b0;
      short_keypress_flag <= 1'b0;
      button_bits         <= 13'h0000;
      mask_hold_reg       <= 1'b0;
      irq_out_n           <= 1'b1;
    end
    else if (sw_reset)
    begin
      key_prev_reg        <= 1'b0;
      short_keypress_flag <= 1'b0;
      button_bits         <= 13'h0000;
      mask_hold_reg       <= 1'b1;
      irq_out_n           <= 1'b0;
    end
    else
    begin
      key_prev_reg <= key_stable && is_key(adc_code);
      if (mask_hold_reg && reg_wr && !int_mask)
        mask_hold_reg <= 1'b0;
      // release sets flag; wins over clear
      if (key_prev_reg && !key_stable)
      begin
        short_keypress_flag <= 1'b1;
        button_bits <= 13'h0001 << (adc_code - 5'h01);
      end
      else if (int_rd)
        short_keypress_flag <= 1'b0;
      irq_out_n <= !(mask_hold_reg ||
                     (short_keypress_flag && !int_mask));
    end
  end
endmodule // uad_ctrl

// [verif/uad_ctrl_chk.sv]
// Port-level assertions for uad_ctrl: decode relations and timeouts.
// Bound to uad_ctrl; sense inputs pass two sync flops inside it.
`timescale 1ns/10ps
module uad_ctrl_chk
(
  input wire logic       clk, // clock
  input wire logic       rst_n, // sync reset
  input wire logic       vbus_ok, // vbus sense
  input wire logic       io_supply, // io supply
  input wire logic       over_thr, // overcurrent
  input wire logic       alt_mode, // alt table
  input wire logic       int_rd, // irq read
  input wire logic       key_stable, // key level
  input wire logic       sw_reset, // soft reset
  input wire logic [7:0] ocp_timeout, // oc delay
  input wire logic       sw_usb, // usb path
  input wire logic       sw_uart, // uart path
  input wire logic       sw_audio, // audio path
  input wire logic       sw_vbus_mic, // vbus to mic
  input wire logic       sw_dm_left, // dm to left
  input wire logic       sw_dp_mic, // dp to mic
  input wire logic       id_bypass_switch, // id bypass
  input wire logic       charge_current_out, // charge status
  input wire logic       factory_cable_out, // jig status
  input wire logic       boot_out, // boot status
  input wire logic       load_sw_en, // load switch
  input wire logic       reg_access_en, // reg access
  input wire logic [4:0] adc_code, // id code
  input wire logic       short_keypress_flag, // key flag
  input wire logic       irq_out_n, // irq low
  input wire logic       standby // idle
);
  logic [8:0] oc_cnt_reg;
  // Length of the present overcurrent episode, saturating
  always @(posedge clk)
  begin
    if (!rst_n || !over_thr)
      oc_cnt_reg <= 9'h000;
    else if (oc_cnt_reg != 9'h1ff)
      oc_cnt_reg <= oc_cnt_reg + 9'h001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_load_vbus: assert property ((!vbus_ok) [*4] |=> !load_sw_en)
    else $error("load switch on without vbus");
  chk_reg_gate: assert property ((!io_supply) [*4] |=> !reg_access_en)
    else $error("register access without io supply");
  chk_key_audio: assert property ((!standby && !alt_mode && sw_audio
    && adc_code >= 5'h01 && adc_code <= 5'h0d) |-> (sw_vbus_mic && !sw_usb
    && !sw_uart && !id_bypass_switch && !factory_cable_out && !boot_out))
    else $error("key code path wrong");
  chk_boot_code: assert property (boot_out |->
    (adc_code == 5'h19 || adc_code == 5'h1d))
    else $error("boot out on wrong code");
  chk_jig_path: assert property (factory_cable_out |-> sw_usb != sw_uart)
    else $error("jig without one data path");
  chk_charge_current_out_open: assert property ((charge_current_out
    && adc_code == 5'h1f) |-> (sw_usb && id_bypass_switch))
    else $error("charge current without usb and bypass");
  chk_alt_route: assert property (sw_dp_mic |->
    (sw_dm_left && !sw_vbus_mic && !sw_usb))
    else $error("dp to mic route wrong");
  chk_irq_clear: assert property ((int_rd && !key_stable
    && !$past(key_stable, 4)) |-> ##[1:2] !short_keypress_flag)
    else $error("key flag not cleared by read");
  chk_swrst_irq: assert property (sw_reset |-> ##[1:3] !irq_out_n)
    else $error("irq not low after soft reset");
  chk_idle_open: assert property ((standby && $past(standby)) |->
    !(sw_uart || sw_audio || sw_vbus_mic || sw_dm_left || sw_dp_mic
    || factory_cable_out || boot_out) && (adc_code == 5'h1f
    || !(sw_usb || id_bypass_switch)))
    else $error("path closed while idle");
  chk_ocp_trip: assert property ((oc_cnt_reg >
    {1'b0, ocp_timeout} + 9'h004) |-> !load_sw_en)
    else $error("load switch on past overcurrent timeout");
endmodule // uad_ctrl_chk

bind uad_ctrl uad_ctrl_chk u_chk (.clk, .rst_n, .vbus_ok, .io_supply,
  .over_thr, .alt_mode, .int_rd, .key_stable, .sw_reset, .ocp_timeout,
  .sw_usb, .sw_uart, .sw_audio, .sw_vbus_mic, .sw_dm_left, .sw_dp_mic,
  .id_bypass_switch, .charge_current_out, .factory_cable_out, .boot_out,
  .load_sw_en, .reg_access_en, .adc_code, .short_keypress_flag,
  .irq_out_n, .standby);

// [verif/uad_acc_model.sv]
// Accessory or charger on the connector, seen through the sense pins.
// Assumes adc_code shows the ramping reference during conversion.
`timescale 1ns/10ps
`include "uad_defines.vh"
module uad_acc_model
(
  input  wire logic       attach, // id resistor fitted
  input  wire logic       vbus_on, // vbus applied
  input  wire logic [2:0] chg, // charger kind
  input  wire logic [4:0] target, // code of the resistor
  input  wire logic [4:0] adc_code, // reference code
  input  wire logic       press, // key held
  output logic            vbus_ok, // vbus above 4 V
  output logic            id_attached, // resistor seen
  output logic            id_cmp_hi, // id above reference
  output logic            conn_dplus, // d+ state
  output logic            conn_dminus, // d- state
  output logic            dlines_short, // lines shorted
  output logic            dminus_src, // d- sourcing
  output logic            key_stable // key level
);
  assign id_attached = attach;
  assign id_cmp_hi = attach && (adc_code < target);
  assign key_stable = attach && press;
  assign vbus_ok = vbus_on;
  assign dlines_short = vbus_on && chg == `UAD_CHG_DCP;
  assign dminus_src = vbus_on && chg == `UAD_CHG_CDP;
  // Pulled-down lines read 1; open lines read 0
  assign conn_dplus = vbus_on && (chg == `UAD_CHG_SDP
                        || chg == `UAD_CHG_CDP);
  assign conn_dminus = vbus_on && chg == `UAD_CHG_SDP;
endmodule // uad_acc_model

// [verif/testbench.sv]
// Self-checking bench for uad_ctrl with the accessory model.
// Needs uad_defines.vh on the include path.
`timescale 1ns/10ps
`include "uad_defines.vh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic clk, rst_n, vbat_ok, io_supply, over_thr, alt_mode, int_mask;
  logic sw_reset, int_rd, reg_wr, attach, vbus_on, press;
  logic [2:0] chg;
  logic [4:0] target;
  logic [7:0] ocp_timeout;
  logic [9:0] exp_v;
  wire vbus_ok, id_cmp_hi, id_attached, conn_dplus, conn_dminus;
  wire dlines_short, dminus_src, key_stable, sw_usb, sw_uart, sw_audio;
  wire sw_vbus_mic, sw_dm_left, sw_dp_mic, id_bypass_switch, boot_out;
  wire charge_current_out, factory_cable_out, load_sw_en, standby;
  wire current_limit_en, id_src_en, reg_access_en, short_keypress_flag;
  wire irq_out_n;
  wire [4:0] adc_code;
  wire [2:0] charger_type;
  wire [12:0] button_bits;
  wire [9:0] swv = {sw_usb, sw_uart, sw_audio, sw_vbus_mic, sw_dm_left,
    sw_dp_mic, id_bypass_switch, charge_current_out, factory_cable_out,
    boot_out};
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int i, n;
  // Row: alt, vbus, attach, charger, code, expected paths
  localparam logic [20:0] ROWS [16] = '{
    {3'b001, 3'h0, 5'h01, 10'h0c0}, {3'b001, 3'h0, 5'h0d, 10'h0c0},
    {3'b001, 3'h0, 5'h18, 10'h202}, {3'b001, 3'h0, 5'h19, 10'h203},
    {3'b001, 3'h0, 5'h1c, 10'h102}, {3'b001, 3'h0, 5'h1d, 10'h103},
    {3'b001, 3'h0, 5'h1e, 10'h0c0}, {3'b101, 3'h0, 5'h1c, 10'h030},
    {3'b101, 3'h0, 5'h1d, 10'h030}, {3'b101, 3'h0, 5'h10, 10'h0c0},
    {3'b101, 3'h0, 5'h11, 10'h0c0}, {3'b010, 3'h1, 5'h1f, 10'h208},
    {3'b010, 3'h2, 5'h1f, 10'h20c}, {3'b010, 3'h3, 5'h1f, 10'h20c},
    {3'b010, 3'h4, 5'h1f, 10'h000}, {3'b001, 3'h0, 5'h07, 10'h0c0}};

  uad_ctrl u_uad_ctrl (.clk, .rst_n, .vbat_ok, .vbus_ok, .io_supply,
    .id_cmp_hi, .id_attached, .conn_dplus, .conn_dminus, .dlines_short,
    .dminus_src, .over_thr, .alt_mode, .int_mask, .sw_reset, .int_rd,
    .reg_wr, .key_stable, .ocp_timeout, .sw_usb, .sw_uart, .sw_audio,
    .sw_vbus_mic, .sw_dm_left, .sw_dp_mic, .id_bypass_switch,
    .charge_current_out, .factory_cable_out, .boot_out, .load_sw_en,
    .current_limit_en, .id_src_en, .reg_access_en, .adc_code,
    .charger_type, .short_keypress_flag, .button_bits, .irq_out_n,
    .standby);
  uad_acc_model u_uad_acc_model (.attach, .vbus_on, .chg, .target,
    .adc_code, .press, .vbus_ok, .id_attached, .id_cmp_hi, .conn_dplus,
    .conn_dminus, .dlines_short, .dminus_src, .key_stable);

  always #20 clk = ~clk;

  task automatic tick;
    @(posedge clk);
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Ceiling well above the expected run of about 1000 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      stop_test();
    end
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {vbat_ok, io_supply, over_thr, alt_mode, int_mask} = 5'b11000;
    {sw_reset, int_rd, reg_wr, attach, vbus_on, press} = 6'h00;
    chg = `UAD_CHG_NONE;
    target = 5'h1f;
    ocp_timeout = `UAD_OCP_TMO_RESET;
    repeat (12) tick();
    `CHK({adc_code, standby, irq_out_n}, {5'h1f, 2'b11})
    rst_n = 1'b1;
    for (i = 0; i < 16; i++)
    begin
      {alt_mode, vbus_on, attach, chg, target, exp_v} = ROWS[i];
      for (n = 0; n < 200 && (swv !== exp_v || load_sw_en !== vbus_on);
        n++) tick();
      `CHK(swv, exp_v)
      `CHK(load_sw_en, vbus_on)
      `CHK(adc_code, target)
      `CHK(id_src_en, attach)
      `CHK(charger_type, chg)
      {attach, vbus_on, chg} = 5'h00;
      for (n = 0; n < 100 && {standby, swv, load_sw_en} !== 12'h800; n++)
        tick();
      `CHK({standby, swv, load_sw_en}, 12'h800)
    end
    io_supply = 1'b0;
    for (n = 0; n < 10 && reg_access_en !== 1'b0; n++) tick();
    `CHK(reg_access_en, 1'b0)
    repeat (4) tick();
    io_supply = 1'b1;
    {alt_mode, attach, press, target} = {3'b011, `UAD_ADC_KEY_LO};
    for (n = 0; n < 100 && swv !== 10'h0c0; n++) tick();
    press = 1'b0;
    for (n = 0; n < 20 && irq_out_n !== 1'b0; n++) tick();
    `CHK({short_keypress_flag, button_bits[0], irq_out_n}, 3'b110)
    repeat (4) tick();
    int_rd = 1'b1;
    tick();
    int_rd = 1'b0;
    for (n = 0; n < 10 && irq_out_n !== 1'b1; n++) tick();
    `CHK({short_keypress_flag, irq_out_n}, 2'b01)
    {int_mask, sw_reset} = 2'b11;
    tick();
    sw_reset = 1'b0;
    `CHK(adc_code, `UAD_ADC_RESET)
    repeat (20) tick();
    `CHK(irq_out_n, 1'b0)
    {int_mask, reg_wr, attach} = 3'b010;
    tick();
    reg_wr = 1'b0;
    for (n = 0; n < 10 && irq_out_n !== 1'b1; n++) tick();
    `CHK(irq_out_n, 1'b1)
    {vbus_on, chg, over_thr} = {1'b1, `UAD_CHG_SDP, 1'b0};
    for (n = 0; n < 20 && load_sw_en !== 1'b1; n++) tick();
    over_thr = 1'b1;
    repeat (6) tick();
    `CHK(current_limit_en, 1'b1)
    over_thr = 1'b0;
    repeat (20) tick();
    `CHK(load_sw_en, 1'b1)
    over_thr = 1'b1;
    for (n = 0; n < 40 && load_sw_en !== 1'b0; n++) tick();
    `CHK(load_sw_en, 1'b0)
    {over_thr, vbus_on, vbat_ok} = 3'b000;
    for (n = 0; n < 20 &&
      {standby, swv, load_sw_en, reg_access_en} !== 13'h1000; n++) tick();
    `CHK({standby, swv, load_sw_en, reg_access_en}, 13'h1000)
    stop_test();
  end
endmodule // testbench
